/* File: rtl/llsip_framer.sv */
/*
 * System information packet field framer: passes link packets from a slot
 * stream to an output stream, builds info packets on command and updates
 * forwarded ones. Assumes slot 0 is the first byte after idle and that the
 * serialiser behind the output applies break and mark timing itself.
 */
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module llsip_framer
  import llsip_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        in_data,
  input  wire logic              in_last,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic [7:0]             out_data,
  output logic                   out_first,
  output logic                   out_last,
  output logic                   out_valid,
  input  wire logic              out_ready
);

  if (ADDR_W < 5 || ADDR_W > 12) begin : g_chk
    $error("llsip_framer: ADDR_W must lie in 5..12");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    llsip_state_t state;
    logic [9:0]   slot;
    logic [7:0]   sum8;
    logic [15:0]  sum16;
    logic [15:0]  prev_sum;
    logic         prev_asc;
    logic         cur_asc;
    logic         cur_sip;
    logic         sip_fwd;
    logic [7:0]   cnt_byte;
    logic [7:0]   lvl;
    logic [15:0]  pkt_cnt;
    logic [7:0]   seq;
    logic         gen_req;
    logic [3:0]   ctrl;
    logic [7:0]   ver;
    logic [7:0]   univ;
    logic [7:0]   alt;
    logic [15:0]  len;
    logic [15:0]  mfr;
    logic         len_err;
    logic         mfr_err;
    logic         drop_err;
    logic         o_v;
    logic [7:0]   o_d;
    logic         o_f;
    logic         o_l;
    logic         k_v;
    logic [7:0]   k_d;
    logic         k_f;
    logic         k_l;
    logic         in_rdy;
    logic         aw_got;
    logic [11:0]  aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         awrdy;
    logic         wrdy;
    logic         bv;
    logic [1:0]   bresp;
    logic         arrdy;
    logic         rv;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } llsip_st_t;

  llsip_st_t  st_ff;
  llsip_st_t  nxt_st;
  logic       push;
  logic [7:0] pbyte;
  logic       pfirst;
  logic       plast;
  logic       take;
  logic       pop;
  logic       filtered;
  logic [9:0] hist_slot;
  logic [15:0] mfr_tx;
  logic [15:0] len_tx;
  logic [11:0] raddr;

  assign take      = in_valid && st_ff.in_rdy;
  assign pop       = st_ff.o_v && out_ready;
  assign hist_slot = SLOT_MFR_HI + {1'b0, st_ff.lvl, 1'b0};
  // Undeclared identifier replaces the development code outside development builds
  assign mfr_tx    = (st_ff.mfr == MFR_DEV && !st_ff.ctrl[CTRL_DEV_BIT]) ? MFR_NONE : st_ff.mfr;
  assign len_tx    = len_legal(st_ff.len) ? st_ff.len : LEN_RST;
  assign filtered  = st_ff.ctrl[CTRL_FILT_BIT] && in_data != NULL_CODE && in_data != SIP_CODE &&
                     (in_data != st_ff.alt || st_ff.alt == NULL_CODE);
  assign raddr     = 12'(s_axi_araddr);

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    push   = 1'b0;
    pbyte  = 8'h00;
    pfirst = 1'b0;
    plast  = 1'b0;

    // Register bus: address and data taken in either order
    if (s_axi_awvalid && st_ff.awrdy) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = 12'(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_ff.wrdy) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bv && s_axi_bready) begin
      nxt_st.bv = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bv) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bv     = 1'b1;
      nxt_st.bresp  = RESP_OK;
      case (st_ff.aw_addr)
        ADDR_CTRL: begin
          nxt_st.ctrl = 4'(merge_strb(32'(st_ff.ctrl), st_ff.w_data, st_ff.w_strb));
        end
        ADDR_CFG: begin
          {nxt_st.alt, nxt_st.univ, nxt_st.ver} =
            24'(merge_strb({8'h00, st_ff.alt, st_ff.univ, st_ff.ver}, st_ff.w_data, st_ff.w_strb));
        end
        ADDR_LEN: begin
          nxt_st.len = 16'(merge_strb(32'(st_ff.len), st_ff.w_data, st_ff.w_strb));
          if (!len_legal(nxt_st.len)) begin
            nxt_st.len_err = 1'b1;
          end
        end
        ADDR_MFR: begin
          nxt_st.mfr = 16'(merge_strb(32'(st_ff.mfr), st_ff.w_data, st_ff.w_strb));
          if (nxt_st.mfr == MFR_DEV && !st_ff.ctrl[CTRL_DEV_BIT]) begin
            nxt_st.mfr_err = 1'b1;
          end
        end
        ADDR_CMD: begin
          if (st_ff.w_strb[0] && st_ff.w_data[0]) begin
            nxt_st.gen_req = 1'b1;
          end
        end
        ADDR_STATUS: begin
          // Write one to clear; stream events below win over the clear
          if (st_ff.w_strb[3]) begin
            nxt_st.len_err  = st_ff.len_err && !st_ff.w_data[ST_LEN_BIT];
            nxt_st.mfr_err  = st_ff.mfr_err && !st_ff.w_data[ST_MFR_BIT];
            nxt_st.drop_err = st_ff.drop_err && !st_ff.w_data[ST_DROP_BIT];
          end
        end
        default: begin
          nxt_st.bresp = RESP_ERR;
        end
      endcase
    end
    nxt_st.awrdy = !nxt_st.aw_got && !nxt_st.bv;
    nxt_st.wrdy  = !nxt_st.w_got && !nxt_st.bv;

    if (st_ff.rv && s_axi_rready) begin
      nxt_st.rv = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arrdy) begin
      nxt_st.rv    = 1'b1;
      nxt_st.rresp = RESP_OK;
      case (raddr)
        ADDR_CTRL:   nxt_st.rdata = 32'(st_ff.ctrl);
        ADDR_CFG:    nxt_st.rdata = {8'h00, st_ff.alt, st_ff.univ, st_ff.ver};
        ADDR_LEN:    nxt_st.rdata = 32'(st_ff.len);
        ADDR_MFR:    nxt_st.rdata = 32'(st_ff.mfr);
        ADDR_CMD:    nxt_st.rdata = 32'h0000_0000;
        ADDR_STATUS: nxt_st.rdata = {4'h0, st_ff.drop_err, st_ff.mfr_err, st_ff.len_err,
                                     st_ff.gen_req || st_ff.state == S_GEN, st_ff.seq, st_ff.pkt_cnt};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_ERR;
        end
      endcase
    end
    nxt_st.arrdy = !nxt_st.rv;

    // Slot stream
    case (st_ff.state)
      S_IDLE: begin
        if (take) begin
          if (filtered) begin
            nxt_st.drop_err = 1'b1;
            nxt_st.state    = in_last ? S_IDLE : S_DROP;
          end else begin
            push            = 1'b1;
            pbyte           = in_data;
            pfirst          = 1'b1;
            plast           = in_last;
            nxt_st.sum8     = in_data;
            nxt_st.sum16    = 16'(in_data);
            nxt_st.slot     = SLOT_COUNT;
            nxt_st.cnt_byte = 8'h00;
            nxt_st.lvl      = 8'h00;
            nxt_st.cur_asc  = in_data != NULL_CODE;
            nxt_st.cur_sip  = in_data == SIP_CODE;
            nxt_st.sip_fwd  = in_data == SIP_CODE && st_ff.ctrl[CTRL_FWD_BIT];
            nxt_st.state    = in_last ? S_IDLE : S_PASS;
            if (in_data != SIP_CODE && st_ff.pkt_cnt != COUNT_MAX) begin
              nxt_st.pkt_cnt = st_ff.pkt_cnt + 16'h0001;
            end
          end
        end else if (st_ff.gen_req && !st_ff.k_v) begin
          nxt_st.gen_req = 1'b0;
          nxt_st.state   = S_GEN;
          nxt_st.slot    = 10'h000;
        end
      end
      S_PASS: begin
        if (take) begin
          push  = 1'b1;
          pbyte = in_data;
          plast = in_last;
          if (st_ff.sip_fwd) begin
            if (st_ff.slot == SLOT_COUNT) begin
              nxt_st.cnt_byte = in_data;
            end
            if (st_ff.slot == SLOT_LEVEL) begin
              pbyte      = (in_data == LEVEL_SAT) ? in_data : 8'(in_data + 8'h01);
              nxt_st.lvl = pbyte;
            end
            if (st_ff.lvl != 8'h00 && st_ff.lvl <= LEVEL_MAX_HOP) begin
              if (st_ff.slot == hist_slot) begin
                pbyte = mfr_tx[15:8];
              end
              if (st_ff.slot == hist_slot + 10'h001) begin
                pbyte = mfr_tx[7:0];
              end
            end
            if (st_ff.slot > SLOT_COUNT && st_ff.slot == {2'h0, st_ff.cnt_byte}) begin
              pbyte = st_ff.sum8;
            end
          end
          nxt_st.slot = st_ff.slot + 10'h001;
          if (in_last) begin
            nxt_st.state = S_IDLE;
          end
        end
      end
      S_DROP: begin
        if (take && in_last) begin
          nxt_st.state = S_IDLE;
        end
      end
      S_GEN: begin
        if (!st_ff.k_v) begin
          push   = 1'b1;
          pfirst = st_ff.slot == 10'h000;
          plast  = st_ff.slot == {2'h0, SIP_COUNT};
          case (st_ff.slot)
            10'h000:     pbyte = SIP_CODE;
            SLOT_COUNT:  pbyte = SIP_COUNT;
            SLOT_CTRL:   pbyte = {6'h00, st_ff.prev_asc, 1'b0};
            SLOT_SUM_HI: pbyte = st_ff.prev_sum[15:8];
            SLOT_SUM_LO: pbyte = st_ff.prev_sum[7:0];
            SLOT_SEQ:    pbyte = st_ff.seq;
            SLOT_UNIV:   pbyte = st_ff.univ;
            SLOT_LEVEL:  pbyte = 8'h00;
            SLOT_VER:    pbyte = st_ff.ctrl[CTRL_VER_BIT] ? st_ff.ver : 8'h00;
            SLOT_LEN_HI: pbyte = len_tx[15:8];
            SLOT_LEN_LO: pbyte = len_tx[7:0];
            SLOT_CNT_HI: pbyte = st_ff.pkt_cnt[15:8];
            SLOT_CNT_LO: pbyte = st_ff.pkt_cnt[7:0];
            SLOT_MFR_HI: pbyte = mfr_tx[15:8];
            SLOT_MFR_LO: pbyte = mfr_tx[7:0];
            {2'h0, SIP_COUNT}: pbyte = st_ff.sum8;
            default:     pbyte = 8'h00;
          endcase
          nxt_st.slot = st_ff.slot + 10'h001;
          if (plast) begin
            nxt_st.state   = S_IDLE;
            nxt_st.seq     = st_ff.seq + 8'h01;
            nxt_st.pkt_cnt = 16'h0000;
          end
        end
      end
      default: begin
        nxt_st.state = S_IDLE;
      end
    endcase

    if (push) begin
      nxt_st.sum8  = pfirst ? pbyte : ocsum8(st_ff.sum8, pbyte);
      nxt_st.sum16 = pfirst ? 16'(pbyte) : ocsum16(st_ff.sum16, pbyte);
      // Only ordinary packets feed the next info packet's history
      if (plast && st_ff.state != S_GEN && !(pfirst ? in_data == SIP_CODE : st_ff.cur_sip)) begin
        nxt_st.prev_sum = nxt_st.sum16;
        nxt_st.prev_asc = pfirst ? in_data != NULL_CODE : st_ff.cur_asc;
      end
    end

    // Two-entry buffer: head drives the port, second entry absorbs a stall
    if (pop || !st_ff.o_v) begin
      if (st_ff.k_v) begin
        nxt_st.o_v = 1'b1;
        nxt_st.o_d = st_ff.k_d;
        nxt_st.o_f = st_ff.k_f;
        nxt_st.o_l = st_ff.k_l;
        nxt_st.k_v = 1'b0;
      end else begin
        nxt_st.o_v = push;
        nxt_st.o_d = pbyte;
        nxt_st.o_f = pfirst;
        nxt_st.o_l = plast;
      end
    end else if (push) begin
      nxt_st.k_v = 1'b1;
      nxt_st.k_d = pbyte;
      nxt_st.k_f = pfirst;
      nxt_st.k_l = plast;
    end
    // Pending generation holds the input off so it starts at a packet boundary
    nxt_st.in_rdy = !nxt_st.k_v && nxt_st.state != S_GEN && !(nxt_st.state == S_IDLE && nxt_st.gen_req);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awrdy;
  assign s_axi_wready  = st_ff.wrdy;
  assign s_axi_bvalid  = st_ff.bv;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arrdy;
  assign s_axi_rvalid  = st_ff.rv;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign in_ready      = st_ff.in_rdy;
  assign out_valid     = st_ff.o_v;
  assign out_data      = st_ff.o_d;
  assign out_first     = st_ff.o_f;
  assign out_last      = st_ff.o_l;

  // ==========================================================================
  // Checks
  a_ver_slot: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot == SLOT_VER |->
    pbyte == (st_ff.ctrl[CTRL_VER_BIT] ? st_ff.ver : 8'h00)) else $error("version slot wrong");
  // Whole field checked at the high byte; a stall would leave the next cycle's byte unrelated
  a_len_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot == SLOT_LEN_HI |->
    !({pbyte, len_tx[7:0]} > LEN_FIX_MAX && {pbyte, len_tx[7:0]} < LEN_DYN)) else $error("reserved length");
  a_len_dyn: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot == SLOT_LEN_HI |->
    {pbyte, len_tx[7:0]} <= LEN_DYN_MAX) else $error("reserved dynamic length");
  a_count_sat: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.pkt_cnt == COUNT_MAX && st_ff.state != S_GEN |=> st_ff.pkt_cnt == COUNT_MAX)
    else $error("packet count wrapped");
  a_mfr_dev: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot == SLOT_MFR_HI && !st_ff.ctrl[CTRL_DEV_BIT] |->
    {pbyte, mfr_tx[7:0]} != MFR_DEV) else $error("development identifier sent");
  a_hist_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot > SLOT_MFR_LO && st_ff.slot < {2'h0, SIP_COUNT} |->
    pbyte == 8'h00) else $error("history slot not zero");
  a_hist_ins: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_PASS && st_ff.sip_fwd && st_ff.lvl == 8'h01 && st_ff.slot == SLOT_MFR_LO + 10'h001
    |-> pbyte == mfr_tx[15:8]) else $error("identifier not inserted");
  a_sip_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && st_ff.slot == {2'h0, SIP_COUNT} |-> pbyte == st_ff.sum8 && plast)
    else $error("info checksum wrong");
  a_start_cf: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_GEN && pfirst |-> pbyte == SIP_CODE) else $error("bad start code");
  a_drop_code: assert property (@(posedge aclk) disable iff (!aresetn)
    take && st_ff.state == S_IDLE && filtered && !in_last |=> st_ff.state == S_DROP && st_ff.drop_err)
    else $error("unregistered code passed");
  a_level_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_PASS && st_ff.sip_fwd && st_ff.slot == SLOT_LEVEL && in_data != LEVEL_SAT
    |-> pbyte == 8'(in_data + 8'h01)) else $error("level not incremented");
  a_fwd_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    push && st_ff.state == S_PASS && st_ff.sip_fwd && st_ff.slot > SLOT_COUNT &&
    st_ff.slot == {2'h0, st_ff.cnt_byte} |-> pbyte == st_ff.sum8) else $error("checksum not rebuilt");

endmodule

/* File: rtl/llsip_pkg.sv */
/*
 * Constants, types and helper functions for the system information packet
 * field framer. Assumes one 20 MHz clock and an AXI4-Lite register bus.
 */
// Functional notes
// - Version slot is 00h when disabled, else the configured firmware version.
// - Declared length 0000h or 0001h-0200h; 0201h-7FFFh never sent.
// - Dynamic length 8000h or 8001h-8200h; 8201h-FFFFh never sent.
// - Packets sent since last info packet counted in 16 bits, saturating.
// - Manufacturer identifiers are 16 bits; 0000h means undeclared.
// - Identifier FFFFh sent only when the development build flag is set.
// - Originator puts its identifier in slots 13/14, zeros in 15-23.
// - Forwarded info packets at level 01h-04h get this device's identifier written in.
// - Forwarding pair chosen by processing level: 01h second, 02h third.
// - Last slot holds 8-bit ones complement sum from start code CFh.
// - Slot 0 carries the start code matching the packet contents.
// - Packets other than null and CFh pass only with a registered nonzero alternate code.
// - Originator sends level 00h; forwarding adds 01h to a level below FFh.
// - Slot 1 sent as 24; received value locates the checksum slot.
package llsip_pkg;

  // ==========================================================================
  // Slot layout
  localparam logic [7:0] SIP_CODE      = 8'hCF;
  localparam logic [7:0] NULL_CODE     = 8'h00;
  localparam logic [7:0] SIP_COUNT     = 8'h18;
  localparam logic [9:0] SLOT_COUNT    = 10'h001;
  localparam logic [9:0] SLOT_CTRL     = 10'h002;
  localparam logic [9:0] SLOT_SUM_HI   = 10'h003;
  localparam logic [9:0] SLOT_SUM_LO   = 10'h004;
  localparam logic [9:0] SLOT_SEQ      = 10'h005;
  localparam logic [9:0] SLOT_UNIV     = 10'h006;
  localparam logic [9:0] SLOT_LEVEL    = 10'h007;
  localparam logic [9:0] SLOT_VER      = 10'h008;
  localparam logic [9:0] SLOT_LEN_HI   = 10'h009;
  localparam logic [9:0] SLOT_LEN_LO   = 10'h00A;
  localparam logic [9:0] SLOT_CNT_HI   = 10'h00B;
  localparam logic [9:0] SLOT_CNT_LO   = 10'h00C;
  localparam logic [9:0] SLOT_MFR_HI   = 10'h00D;
  localparam logic [9:0] SLOT_MFR_LO   = 10'h00E;
  localparam logic [7:0] LEVEL_MAX_HOP = 8'h04;
  localparam logic [7:0] LEVEL_SAT     = 8'hFF;

  // ==========================================================================
  // Field values
  localparam logic [15:0] LEN_FIX_MAX = 16'h0200;
  localparam logic [15:0] LEN_DYN     = 16'h8000;
  localparam logic [15:0] LEN_DYN_MAX = 16'h8200;
  localparam logic [15:0] MFR_NONE    = 16'h0000;
  localparam logic [15:0] MFR_DEV     = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

  // ==========================================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CFG    = 12'h004;
  localparam logic [11:0] ADDR_LEN    = 12'h008;
  localparam logic [11:0] ADDR_MFR    = 12'h00C;
  localparam logic [11:0] ADDR_CMD    = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam int CTRL_FWD_BIT  = 0;
  localparam int CTRL_FILT_BIT = 1;
  localparam int CTRL_DEV_BIT  = 2;
  localparam int CTRL_VER_BIT  = 3;
  localparam int CFG_VER_LSB   = 0;
  localparam int CFG_UNIV_LSB  = 8;
  localparam int CFG_ALT_LSB   = 16;
  localparam int ST_SEQ_LSB    = 16;
  localparam int ST_BUSY_BIT   = 24;
  localparam int ST_LEN_BIT    = 25;
  localparam int ST_MFR_BIT    = 26;
  localparam int ST_DROP_BIT   = 27;
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [15:0] LEN_RST  = 16'h0000;
  localparam logic [15:0] MFR_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_PASS, S_DROP, S_GEN} llsip_state_t;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] ocsum8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = 9'(a) + 9'(b);
    return 8'(t[7:0] + {7'h00, t[8]});
  endfunction

  function automatic logic [15:0] ocsum16(input logic [15:0] a, input logic [7:0] b);
    logic [16:0] t;
    t = 17'(a) + 17'(b);
    return 16'(t[15:0] + {15'h0000, t[16]});
  endfunction

  function automatic logic len_legal(input logic [15:0] v);
    return (v <= LEN_FIX_MAX) || ((v >= LEN_DYN) && (v <= LEN_DYN_MAX));
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: testbench/llsip_sink.sv */
/* Downstream receiver model for the framer's output stream.
   Assumes out_* follow valid/ready on the rising edge of aclk. */
`timescale 1ns/1ps
module llsip_sink (
  input  wire logic       aclk,
  input  wire logic [7:0] out_data,
  input  wire logic       out_first,
  input  wire logic       out_last,
  input  wire logic       out_valid,
  output logic            out_ready
);
  logic [7:0] got[$];
  logic [1:0] fl[$];
  logic [7:0] lfsr = 8'h5b;
  initial out_ready = 1'b0;
  // Random stalls so a lost or repeated byte shows up
  always @(posedge aclk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      fl.push_back({out_first, out_last});
    end
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    out_ready <= lfsr[0] | lfsr[2];
  end
endmodule

/* File: testbench/tb_top.sv */
/* Self-checking bench for the info packet framer.
   Assumes the sink model drives out_ready. */
`timescale 1ns/1ps
module tb_top;
  import llsip_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic        s_axi_arvalid = 0, s_axi_rready = 1, in_last = 0, in_valid = 0;
  logic [7:0]  in_data = 0, out_data;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, in_ready, out_valid, out_ready, out_first, out_last;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pk[$], ex[$];
  int          bad_count = 0, n_tests = 0, seed = 32495;
  always #25 aclk = ~aclk;
  llsip_framer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .in_data, .in_last, .in_valid, .in_ready, .out_data, .out_first,
    .out_last, .out_valid, .out_ready);
  llsip_sink snk (.aclk, .out_data, .out_first, .out_last, .out_valid, .out_ready);
  // ==========================================
  // Checks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] s8(input logic [7:0] q[$]);
    logic [8:0] t;
    t = 0;
    foreach (q[i]) t = 9'(t[7:0]) + 9'(t[8]) + 9'(q[i]);
    return 8'(t[7:0] + t[8]);
  endfunction
  function automatic logic [15:0] s16(input logic [7:0] q[$]);
    logic [16:0] t;
    t = 0;
    foreach (q[i]) t = 17'(t[15:0]) + 17'(t[16]) + 17'(q[i]);
    return 16'(t[15:0] + t[16]);
  endfunction
  // ==========================================
  // Bus and stream drivers
  // Expected generated info packet; universe 07h as configured, length 0000h since the configured 0201h is reserved
  function automatic void sip_ex(input logic [7:0] ctl, input logic [7:0] sq, input logic [7:0] ver,
                                 input logic [15:0] cnt, input logic [15:0] mfr);
    logic [15:0] c;
    c = s16(pk);
    ex = {SIP_CODE, SIP_COUNT, ctl, c[15:8], c[7:0], sq, 8'h07, 8'h00, ver, 8'h00, 8'h00,
          cnt[15:8], cnt[7:0], mfr[15:8], mfr[7:0]};
    repeat (9) ex.push_back(8'h00);
    ex.push_back(s8(ex));
  endfunction
  // Response ready lines stay high, so back-to-back calls never assign them twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic snd();
    foreach (pk[i]) begin
      in_data <= pk[i];
      in_last <= (i == pk.size() - 1);
      in_valid <= 1;
      do @(posedge aclk); while (!in_ready);
    end
    in_valid <= 0;
    @(posedge aclk);
  endtask
  // Extra settle cycles catch surplus bytes
  task automatic take();
    repeat (60) @(posedge aclk);
    #1;
    chk(snk.got.size(), ex.size());
    foreach (ex[i]) chk(snk.got[i], ex[i]);
    foreach (ex[i]) chk(snk.fl[i], {i == 0, i == ex.size() - 1});
    snk.got.delete();
    snk.fl.delete();
  endtask
  // ==========================================
  // Scenarios
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    wr(ADDR_CFG, 32'h0000_075A);
    wr(ADDR_LEN, 32'h0000_0201);
    wr(ADDR_MFR, 32'h0000_1234);
    wr(ADDR_CTRL, 32'h0000_0008);
    rd(12'h01C, d, r);
    chk(r, RESP_ERR);
    rd(ADDR_STATUS, d, r);
    chk(d[25], 1'b1);
    pk = {NULL_CODE, 8'($random(seed)), 8'($random(seed))};
    ex = pk;
    snd();
    take();
    wr(ADDR_CMD, 32'h0000_0001);
    sip_ex(8'h00, 8'h00, 8'h5A, 16'h0001, 16'h1234);
    take();
    wr(ADDR_CTRL, 32'h0000_0009);
    pk = {SIP_CODE, SIP_COUNT};
    repeat (23) pk.push_back(8'($random(seed)));
    pk[7] = 8'h00;
    ex = pk;
    ex[7] = 8'h01;
    ex[15] = 8'h12;
    ex[16] = 8'h34;
    void'(ex.pop_back());
    ex.push_back(s8(ex));
    snd();
    take();
    wr(ADDR_CFG, 32'h0055_075A);
    wr(ADDR_CTRL, 32'h0000_0002);
    pk = {8'h33, 8'($random(seed))};
    snd();
    pk = {8'h55, 8'($random(seed))};
    ex = pk;
    snd();
    take();
    rd(ADDR_STATUS, d, r);
    chk(d[27], 1'b1);
    wr(ADDR_MFR, 32'h0000_FFFF);
    rd(ADDR_STATUS, d, r);
    chk(d[26], 1'b1);
    chk(d[23:0], 24'h01_0001);
    wr(ADDR_STATUS, 32'h0E00_0000);
    rd(ADDR_STATUS, d, r);
    chk(d[27:24], 4'h0);
    wr(ADDR_CMD, 32'h0000_0001);
    sip_ex(8'h02, 8'h01, 8'h00, 16'h0001, MFR_NONE);
    take();
    test_done();
  end
  initial begin
    #1_000_000;
    bad_count++;
    test_done();
  end
endmodule
